// [design/bfc_pkg.sv]
package bfc_pkg;
  // frame geometry
  localparam int FRAME_BYTES = 12;
  localparam int SUM_BYTES = 11;
  localparam logic [3:0] LAST_IDX = 4'hb;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  // general command set
  localparam logic [15:0] CMD_PING = 16'hfe01;
  localparam logic [15:0] CMD_IDENT = 16'hfe02;
  localparam logic [15:0] CMD_HW_VERSION_QUERY = 16'hfe06;
  localparam logic [15:0] CMD_FW_VERSION_QUERY = 16'hfe07;
  localparam logic [15:0] CMD_SERIAL_NUMBER_QUERY = 16'hfe08;
  localparam logic [15:0] CMD_NAME_TEXT_QUERY = 16'hfe09;
  localparam logic [7:0] REQ_HIGH = 8'hfe;
  localparam logic [7:0] ANS_HIGH = 8'hff;
  localparam logic [63:0] INDEX_MAX = 64'h0000_0000_0000_00ff;
  // status and fault word commands
  localparam logic [15:0] CMD_STATUS_WORD_QUERY = 16'h0010;
  localparam logic [15:0] CMD_STATUS_WORD_UPDATE = 16'h0011;
  localparam logic [15:0] CMD_FAULT_WORD_QUERY = 16'h0012;
  // error answers
  localparam logic [15:0] RECEIVE_FAIL_REPLY = 16'hff10;
  localparam logic [15:0] REPEAT_REPLY = 16'hff11;
  localparam logic [15:0] BAD_ARGUMENT_REPLY = 16'hff12;
  localparam logic [15:0] UNKNOWN_CODE_REPLY = 16'hff13;
  localparam logic [2:0] REPEAT_LIMIT = 3'h4;
  // laser status word fields
  localparam int ST_NO_FAULT_FLAG = 0;
  localparam int ST_BOOT_DEFAULTS_ENABLE = 1;
  localparam int ST_DEFAULTS_TRIGGER_A = 2;
  localparam int ST_DEFAULTS_TRIGGER_B = 3;
  localparam logic ST_BOOT_RESET = 1'b0;
  // fault word fields
  localparam int FLT_BITS = 5;
  // identity values, arbitrary
  localparam logic [63:0] IDENT_VALUE = 64'h0000_0000_0000_0a5a;
  localparam logic [63:0] HW_VERSION = 64'h0000_0000_0000_0001;
  localparam logic [63:0] FW_VERSION = 64'h0000_0000_0000_0001;
  localparam logic [63:0] SERIAL_BASE = 64'h0000_0000_0000_1000;
  localparam logic [63:0] NAME_BASE = 64'h0000_0000_0000_2000;
  // inter-byte timeout
  localparam int TIMEOUT_CYCLES = 1250;

  typedef struct packed {
    logic [15:0] cmd;
    logic [63:0] param;
  } bfc_frame_t;

  typedef struct packed {
    logic cooler_supply_fault;
    logic diode_supply_fault;
    logic defaults_crc_fault;
    logic panel_driver_crc_fault;
    logic config_crc_fault;
  } bfc_fault_t;

  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_DECIDE = 2'b01,
    ST_SEND = 2'b11
  } bfc_state_t;
endpackage : bfc_pkg

// [design/bfc_handler.sv]
// Functional notes
// [R1] 12-byte frames back to back, else timeout
// [R2] command, parameter, reserved, checksum, MSB first
// [R3] checksum is XOR of first 11 bytes
// [R4] every good frame gets a 12-byte answer
// [R5] no answer means host should retransmit
// [R6] bad parameter answers 0xFF12, zero parameter
// [R7] unknown command answers 0xFF13, zero parameter
// [R8] broken frame answers 0xFF11, up to four
// [R9] fifth broken frame answers 0xFF10
// [R10] error answers carry zero parameter
// [R11] general set 0xFE01-0xFE09 answers 0xFFxx
// [R12] serial/name take 0-255, others zero
// [R13] status word readable and writable
// [R14] status bit 0 reads no fault pending
// [R15] status bit 1 loads defaults at start-up
// [R16] status bit 2 write triggers defaults load
// [R17] status bit 3 write triggers defaults save
// [R18] fault word read-only, bits 5-31 reserved
// [R19] fault bits 0-2 are CRC failures
// [R20] fault bits 3-4 are supply range failures
// [R21] inter-byte timeout is a cycle parameter
// [R22] no fault flag is NOR of faults
// [R23] reserved bits zero, read-only writes ignored
module bfc_handler #(
  parameter int TIMEOUT_CYCLES = bfc_pkg::TIMEOUT_CYCLES
) (
  input wire logic mclk_in, // 125 MHz device clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic [7:0] rx_data_in, // received byte
  input wire logic rx_valid_in, // received byte strobe
  output logic [7:0] tx_data_out, // answer byte
  output logic tx_valid_out, // answer byte valid
  input wire logic tx_ready_in, // link takes answer byte
  input bfc_pkg::bfc_fault_t fault_in, // monitored fault levels
  input wire logic stored_boot_enable_in, // nonvolatile boot flag
  output logic boot_defaults_enable_out, // status bit 1
  output logic load_defaults_out, // one-cycle load pulse
  output logic save_defaults_out // one-cycle save pulse
);

  // frame engine state; idx_q counts bytes on the way in and on the way out
  bfc_pkg::bfc_state_t state_q, state_d;
  logic [3:0] idx_q, idx_d;
  logic [15:0] tmo_q, tmo_d;
  logic [7:0] sum_q, sum_d;
  logic sum_ok_q, sum_ok_d;
  bfc_pkg::bfc_frame_t rx_q, rx_d;
  logic [95:0] ans_q, ans_d;
  logic [2:0] rep_q, rep_d;
  logic boot_q, boot_d;
  logic start_q, start_d;
  logic load_q, load_d;
  logic save_q, save_d;
  bfc_pkg::bfc_fault_t flt_q, flt_d;
  logic [31:0] status_word;
  logic [31:0] fault_word;
  logic no_fault;
  bfc_pkg::bfc_frame_t reply;
  logic bad_arg;
  logic known;
  logic [7:0] reply_sum;
  logic [95:0] reply_bytes;

  // last count of the gap timer: a gap of TIMEOUT_CYCLES idle cycles drops the frame
  localparam logic [15:0] TMO_LAST = 16'(TIMEOUT_CYCLES - 1);

  // fault word mirrors the monitored levels, upper bits reserved
  // one register stage keeps the answer stable while it is built
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      flt_q <= '0;
    end else begin
      flt_q <= flt_d; // [R19] [R20]
    end
  end

  // read views of the two words
  always_comb begin
    // levels, not sticky: a fault bit clears when its input does
    flt_d = fault_in;
    fault_word = {{(32 - bfc_pkg::FLT_BITS){1'b0}}, flt_q}; // [R18] [R23]
    // only the defined fault bits count, reserved bits never raise it
    no_fault = ~(|flt_q); // [R22]
    status_word = '0; // [R23]
    status_word[bfc_pkg::ST_NO_FAULT_FLAG] = no_fault; // [R14]
    status_word[bfc_pkg::ST_BOOT_DEFAULTS_ENABLE] = boot_q;
    // trigger bits always read zero
  end

  // decode the captured frame into an answer
  always_comb begin
    reply.cmd = {bfc_pkg::ANS_HIGH, rx_q.cmd[7:0]}; // [R11]
    reply.param = '0;
    bad_arg = 1'b0;
    known = 1'b1;
    case (rx_q.cmd)
      bfc_pkg::CMD_PING: begin
        bad_arg = (rx_q.param != '0); // [R12]
      end
      bfc_pkg::CMD_IDENT: begin
        bad_arg = (rx_q.param != '0);
        reply.param = bfc_pkg::IDENT_VALUE;
      end
      bfc_pkg::CMD_HW_VERSION_QUERY: begin
        bad_arg = (rx_q.param != '0);
        reply.param = bfc_pkg::HW_VERSION;
      end
      bfc_pkg::CMD_FW_VERSION_QUERY: begin
        bad_arg = (rx_q.param != '0);
        reply.param = bfc_pkg::FW_VERSION;
      end
      bfc_pkg::CMD_SERIAL_NUMBER_QUERY: begin
        bad_arg = (rx_q.param > bfc_pkg::INDEX_MAX); // [R12]
        reply.param = bfc_pkg::SERIAL_BASE | rx_q.param;
      end
      bfc_pkg::CMD_NAME_TEXT_QUERY: begin
        bad_arg = (rx_q.param > bfc_pkg::INDEX_MAX); // [R12]
        reply.param = bfc_pkg::NAME_BASE | rx_q.param;
      end
      bfc_pkg::CMD_STATUS_WORD_QUERY: begin
        bad_arg = (rx_q.param != '0);
        reply.cmd = rx_q.cmd;
        reply.param = {32'h0000_0000, status_word}; // [R13]
      end
      bfc_pkg::CMD_STATUS_WORD_UPDATE: begin
        // only a 32-bit value is meaningful
        bad_arg = (rx_q.param[63:32] != '0);
        reply.cmd = rx_q.cmd;
        reply.param = rx_q.param;
      end
      bfc_pkg::CMD_FAULT_WORD_QUERY: begin
        bad_arg = (rx_q.param != '0);
        reply.cmd = rx_q.cmd;
        reply.param = {32'h0000_0000, fault_word}; // [R18]
      end
      default: begin
        // anything outside the decoded set falls to the unknown answer
        known = 1'b0;
      end
    endcase
    // the checksum is judged before the command, since a broken frame
    // may carry any code; error answers override what the case chose
    if (!sum_ok_q) begin
      // broken frame: repeat until the limit, then give up
      if (rep_q < bfc_pkg::REPEAT_LIMIT) begin
        reply.cmd = bfc_pkg::REPEAT_REPLY; // [R8]
      end else begin
        reply.cmd = bfc_pkg::RECEIVE_FAIL_REPLY; // [R9]
      end
      reply.param = '0; // [R10]
    end else if (!known) begin
      reply.cmd = bfc_pkg::UNKNOWN_CODE_REPLY; // [R7]
      reply.param = '0; // [R10]
    end else if (bad_arg) begin
      reply.cmd = bfc_pkg::BAD_ARGUMENT_REPLY; // [R6]
      reply.param = '0; // [R10]
    end
  end

  // answer checksum over command, parameter and reserved byte
  // the reserved byte only seeds the running xor, the ten others fold in
  always_comb begin
    reply_sum = bfc_pkg::RSVD_BYTE;
    for (int i = 0; i < 10; i++) begin
      reply_sum = reply_sum ^ reply[8 * i +: 8]; // [R3]
    end
    reply_bytes = {reply, bfc_pkg::RSVD_BYTE, reply_sum}; // [R2] [R4]
  end

  // next-state logic for receive, decide and send
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    tmo_d = tmo_q;
    sum_d = sum_q;
    sum_ok_d = sum_ok_q;
    rx_d = rx_q;
    ans_d = ans_q;
    rep_d = rep_q;
    boot_d = boot_q;
    start_d = 1'b0;
    load_d = 1'b0;
    save_d = 1'b0;
    if (start_q) begin
      // stored flag is caught after reset release, not under reset
      // no status update can collide: no frame is complete this early
      boot_d = stored_boot_enable_in;
      load_d = stored_boot_enable_in; // [R15]
    end
    case (state_q)
      bfc_pkg::ST_RECV: begin
        // the reserved byte is summed but not checked, so a host that
        // sends junk there still gets an answer if the checksum holds
        if (rx_valid_in) begin
          // every byte restarts the gap timer, the last one too
          tmo_d = '0;
          if (idx_q == bfc_pkg::LAST_IDX) begin
            sum_ok_d = (sum_q == rx_data_in); // [R3]
            idx_d = '0;
            state_d = bfc_pkg::ST_DECIDE;
          end else begin
            sum_d = sum_q ^ rx_data_in;
            idx_d = idx_q + 4'h1;
            // bytes 1..10 shift in MSB first, byte 11 is reserved
            if (idx_q < 4'ha) begin
              rx_d = {rx_q[71:0], rx_data_in}; // [R2]
            end
          end
        end else if (idx_q != '0) begin
          // a gap mid-frame drops the partial frame silently
          if (tmo_q == TMO_LAST) begin
            idx_d = '0; // [R1] [R21]
            sum_d = '0;
            tmo_d = '0;
          end else begin
            tmo_d = tmo_q + 16'h0001;
          end
        end
      end
      bfc_pkg::ST_DECIDE: begin
        // one cycle to latch the answer puts the decode between two
        // registers, at the cost of one cycle of latency per frame
        ans_d = reply_bytes; // [R4]
        sum_d = '0;
        if (!sum_ok_q) begin
          if (rep_q < bfc_pkg::REPEAT_LIMIT) begin
            rep_d = rep_q + 3'h1; // [R8]
          end else begin
            rep_d = '0; // [R9]
          end
        end else begin
          // a good frame starts the repeat count afresh
          rep_d = '0;
          if (known && !bad_arg && rx_q.cmd == bfc_pkg::CMD_STATUS_WORD_UPDATE) begin
            // read-only and reserved bits are dropped
            boot_d = rx_q.param[bfc_pkg::ST_BOOT_DEFAULTS_ENABLE]; // [R13] [R23]
            load_d = rx_q.param[bfc_pkg::ST_DEFAULTS_TRIGGER_A]; // [R16]
            save_d = rx_q.param[bfc_pkg::ST_DEFAULTS_TRIGGER_B]; // [R17]
          end
        end
        state_d = bfc_pkg::ST_SEND;
      end
      bfc_pkg::ST_SEND: begin
        // incoming bytes are ignored while answering
        // each byte stands until the link raises ready, none is dropped
        if (tx_ready_in) begin
          ans_d = {ans_q[87:0], 8'h00};
          if (idx_q == bfc_pkg::LAST_IDX) begin
            idx_d = '0;
            state_d = bfc_pkg::ST_RECV;
          end else begin
            idx_d = idx_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = bfc_pkg::ST_RECV;
        idx_d = '0;
      end
    endcase
  end

  // registers of the frame engine
  // start_q marks the first cycle after reset for the boot flag
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= bfc_pkg::ST_RECV;
      idx_q <= '0;
      tmo_q <= '0;
      sum_q <= '0;
      sum_ok_q <= 1'b0;
      rx_q <= '0;
      ans_q <= '0;
      rep_q <= '0;
      boot_q <= bfc_pkg::ST_BOOT_RESET;
      start_q <= 1'b1;
      load_q <= 1'b0;
      save_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      tmo_q <= tmo_d;
      sum_q <= sum_d;
      sum_ok_q <= sum_ok_d;
      rx_q <= rx_d;
      ans_q <= ans_d;
      rep_q <= rep_d;
      boot_q <= boot_d;
      start_q <= start_d;
      load_q <= load_d;
      save_q <= save_d;
    end
  end

  // outputs
  // valid is decoded from the state register alone, so it cannot glitch
  assign tx_data_out = ans_q[95:88];
  assign tx_valid_out = (state_q == bfc_pkg::ST_SEND); // [R4]
  assign boot_defaults_enable_out = boot_q;
  assign load_defaults_out = load_q;
  assign save_defaults_out = save_q;

endmodule : bfc_handler

// [verification/bfc_handler_asserts.sv]
module bfc_handler_asserts #(
  parameter int TIMEOUT_CYCLES = 8
) (
  input wire logic mclk_in, // clock
  input wire logic rst_in, // reset
  input wire logic [7:0] rx_data_in, // rx byte
  input wire logic rx_valid_in, // rx strobe
  input wire logic [7:0] tx_data_out, // tx byte
  input wire logic tx_valid_out, // tx valid
  input wire logic tx_ready_in, // tx ready
  input bfc_pkg::bfc_fault_t fault_in, // faults
  input wire logic stored_boot_enable_in, // boot flag
  input wire logic boot_defaults_enable_out, // bit 1
  input wire logic load_defaults_out, // load pulse
  input wire logic save_defaults_out // save pulse
);
  logic [3:0] n_q, n_d;
  logic [7:0] x_q, x_d;
  // bytes taken and running xor, cleared between answers
  always_comb begin
    n_d = n_q;
    x_d = x_q;
    if (!tx_valid_out) begin
      n_d = 4'h0;
      x_d = 8'h00;
    end else if (tx_ready_in) begin
      n_d = n_q + 4'h1;
      x_d = x_q ^ tx_data_out;
    end
  end
  always_ff @(posedge mclk_in) begin
    n_q <= n_d;
    x_q <= x_d;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_answer_holds: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("answer byte moved while stalled");
  a_answer_len: assert property (
    $fell(tx_valid_out) |-> n_q == 4'hc)
    else $error("answer not twelve bytes");
  a_reserved_zero: assert property (
    tx_valid_out && n_q == 4'ha |-> tx_data_out == 8'h00)
    else $error("reserved answer byte not zero");
  a_answer_xor: assert property (
    tx_valid_out && n_q == 4'hb |-> tx_data_out == x_q)
    else $error("answer checksum wrong");
  a_boot_capture: assert property (
    $fell(rst_in) |=> boot_defaults_enable_out == $past(stored_boot_enable_in)
      && load_defaults_out == $past(stored_boot_enable_in))
    else $error("boot flag not taken after reset");
  a_load_single: assert property (
    load_defaults_out |=> !load_defaults_out)
    else $error("load pulse too long");
  a_save_single: assert property (
    save_defaults_out |=> !save_defaults_out)
    else $error("save pulse too long");
  a_answer_delay: assert property (
    $rose(tx_valid_out) |-> $past(rx_valid_in, 2))
    else $error("answer not two cycles after last byte");
endmodule : bfc_handler_asserts

bind bfc_handler bfc_handler_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in),
  .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .fault_in(fault_in), .stored_boot_enable_in(stored_boot_enable_in),
  .boot_defaults_enable_out(boot_defaults_enable_out),
  .load_defaults_out(load_defaults_out), .save_defaults_out(save_defaults_out)
);

// [verification/bfc_host_model.sv]
module bfc_host_model (
  input wire logic mclk_in, // clock
  input wire logic slow_in, // stall answers
  input wire logic [7:0] tx_data_in, // answer byte
  input wire logic tx_valid_in, // answer valid
  output logic tx_ready_out, // answer taken
  output logic [7:0] rx_data_out, // request byte
  output logic rx_valid_out // request strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [95:0] ans;
  int got = 0;
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // when slow, every other cycle stalls so answer bytes must stand
  always @(negedge mclk_in) tx_ready_out <= !slow_in || !tx_ready_out;
  // answer bytes arrive most significant first
  always @(posedge mclk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      ans <= {ans[87:0], tx_data_in};
      got <= got + 1;
    end
  end
  // bad flips a checksum bit; n below 12 leaves the frame partial
  task automatic send(input logic [15:0] c, input logic [63:0] p, input logic bad, input int n);
    logic [95:0] f;
    f = {c, p, 16'h0000};
    for (int i = 0; i < 11; i++) f[7:0] ^= f[95-8*i -: 8];
    f[0] ^= bad;
    got = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_in);
      rx_data_out <= f[95-8*i -: 8];
      rx_valid_out <= 1'b1;
    end
    @(negedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out; // idle line must not look like the last byte
  endtask : send
endmodule : bfc_host_model

// [verification/tb_binary_frame_command_handler.sv]
module tb_binary_frame_command_handler;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TOUT = 8;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic boot_flag = 1'b1;
  logic slow = 1'b0;
  bfc_pkg::bfc_fault_t fault = 5'h00;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, tx_valid, tx_ready, boot_out, load_p, save_p;
  int err_total = 0;
  int check_count = 0;
  int loads = 0;
  int saves = 0;
  always #4 mclk_in = ~mclk_in;
  // count trigger pulses seen at the device outputs
  always @(posedge mclk_in) begin
    if (load_p === 1'b1) loads <= loads + 1;
    if (save_p === 1'b1) saves <= saves + 1;
  end
  bfc_handler #(.TIMEOUT_CYCLES(TOUT)) dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .fault_in(fault), .stored_boot_enable_in(boot_flag), .boot_defaults_enable_out(boot_out),
    .load_defaults_out(load_p), .save_defaults_out(save_p));
  bfc_host_model host (
    .mclk_in(mclk_in), .slow_in(slow), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .rx_data_out(rx_data), .rx_valid_out(rx_valid));
  task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one frame out, wait a bounded time for the whole answer
  task automatic xact(input logic [15:0] c, input logic [63:0] p, input logic bad,
                      input logic [15:0] ec, input logic [63:0] ep);
    host.send(c, p, bad, 12);
    for (int i = 0; i < 100 && host.got < 12; i++) @(negedge mclk_in);
    cmp(80'(host.got), 80'd12);
    cmp(host.ans[95:16], {ec, ep});
  endtask : xact
  task automatic t_general();
    logic [15:0] c [6] = '{16'hfe01, 16'hfe02, 16'hfe06, 16'hfe07, 16'hfe08, 16'hfe09};
    logic [63:0] e [6] = '{64'h0, bfc_pkg::IDENT_VALUE, bfc_pkg::HW_VERSION,
      bfc_pkg::FW_VERSION, bfc_pkg::SERIAL_BASE | 64'hff, bfc_pkg::NAME_BASE};
    for (int i = 0; i < 6; i++)
      xact(c[i], (i == 4) ? 64'hff : 64'h0, 1'b0, {8'hff, c[i][7:0]}, e[i]);
  endtask : t_general
  task automatic t_errors();
    xact(16'h1234, 64'h0, 1'b0, bfc_pkg::UNKNOWN_CODE_REPLY, 64'h0);
    xact(16'hfe08, 64'h100, 1'b0, bfc_pkg::BAD_ARGUMENT_REPLY, 64'h0);
    xact(16'hfe01, 64'h1, 1'b0, bfc_pkg::BAD_ARGUMENT_REPLY, 64'h0);
  endtask : t_errors
  // broken frames resent under a stalling host
  task automatic t_repeat();
    slow = 1'b1;
    for (int i = 0; i < 4; i++) xact(16'hfe01, 64'h0, 1'b1, 16'hff11, 64'h0);
    xact(16'hfe01, 64'h0, 1'b1, bfc_pkg::RECEIVE_FAIL_REPLY, 64'h0);
    xact(16'hfe01, 64'h0, 1'b1, bfc_pkg::REPEAT_REPLY, 64'h0);
    xact(16'hfe01, 64'h0, 1'b0, 16'hff01, 64'h0);
    slow = 1'b0;
  endtask : t_repeat
  task automatic t_timeout();
    host.send(16'hfe01, 64'h0, 1'b0, 5);
    repeat (TOUT + 4) @(negedge mclk_in);
    cmp(80'(host.got), 80'h0);
    xact(16'hfe01, 64'h0, 1'b0, 16'hff01, 64'h0);
  endtask : t_timeout
  task automatic t_status();
    xact(16'h0010, 64'h0, 1'b0, 16'h0010, 64'h3);
    xact(16'h0011, 64'h4, 1'b0, 16'h0011, 64'h4);
    xact(16'h0011, 64'hffff_fffa, 1'b0, 16'h0011, 64'hffff_fffa);
    xact(16'h0010, 64'h0, 1'b0, 16'h0010, 64'h3);
    fault = 5'h15;
    xact(16'h0012, 64'h0, 1'b0, 16'h0012, 64'h15);
    xact(16'h0010, 64'h0, 1'b0, 16'h0010, 64'h2);
    fault = 5'h0a;
    xact(16'h0012, 64'h0, 1'b0, 16'h0012, 64'h0a);
    xact(16'h0011, 64'h1_0000_0000, 1'b0, bfc_pkg::BAD_ARGUMENT_REPLY, 64'h0);
    cmp({15'h0, loads, saves, 1'b1}, {15'h0, 32'd2, 32'd1, boot_out});
  endtask : t_status
  // mid-run reset with the stored boot flag clear: no load pulse, bit 1 low
  task automatic t_reboot();
    boot_flag = 1'b0;
    fault = 5'h00;
    rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    cmp({loads, 47'h0, boot_out}, {32'd2, 47'h0, 1'b0});
    xact(16'h0010, 64'h0, 1'b0, 16'h0010, 64'h1);
  endtask : t_reboot
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(negedge mclk_in);
    rst_in = 1'b0;
    t_general();
    t_errors();
    t_repeat();
    t_timeout();
    t_status();
    t_reboot();
    report_and_stop();
  end
  // watchdog, roughly twenty-five times the expected run
  initial begin
    #160000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_binary_frame_command_handler
